//--- hdl/charger_mode_supervisor.sv
/*
 * charge-mode supervisor: boot mode, timers, faults, status pin, apb registers.
 * assumes analog comparator levels arrive asynchronous; apb master on pclk.
 */
`timescale 1ns/10ps
module charger_mode_supervisor
    import chg_sup_pkg::*;
#(
    parameter longint GOOD_CYCLES = GOOD_CYC,
    parameter longint PWRUP_CYCLES = PWRUP_CYC,
    parameter longint T32_CYCLES = T32_CYC,
    parameter longint T15_CYCLES = T15_CYC,
    parameter longint DETECT_CYCLES = DETECT_CYC,
    parameter longint RETRY_CYCLES = RETRY_CYC,
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter bit HAS_SELECT_PIN = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_select_pin,
    input wire logic thermal_shutdown_in,
    input wire logic vbus_ov_in,
    input wire logic bat_ov_in,
    input wire logic vbus_sleep_in,
    input wire logic vbus_good_in,
    input wire logic vbus_dpm_in,
    input wire logic bat_above_lowv_in,
    input wire logic bat_above_rch_in,
    input wire logic bat_short_in,
    input wire logic term_current_in,
    input wire logic boost_fault_in,
    output logic stat_oe,
    output logic stat_out,
    output logic converter_en,
    output logic block_switch_en,
    output logic vbus_sink_en,
    output logic detect_sink_en,
    output logic short_current_mode,
    output logic dpm_reduce,
    output logic [1:0] in_limit_sel,
    output logic hi_z
);
    // ======================================================================
    // input synchronisers
    localparam int NS = 12;
    logic [NS-1:0] meta_reg;
    logic [NS-1:0] sync_reg;
    wire [NS-1:0] raw_in = {boost_fault_in, supply_select_pin, thermal_shutdown_in,
        vbus_ov_in, bat_ov_in, vbus_sleep_in, vbus_good_in, vbus_dpm_in,
        bat_above_lowv_in, bat_above_rch_in, bat_short_in, term_current_in};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= raw_in;
            sync_reg <= meta_reg;
        end
    end
    wire term_s = sync_reg[0];
    wire short_s = sync_reg[1];
    wire rch_s = sync_reg[2];
    wire lowv_s = sync_reg[3];
    wire dpm_s = sync_reg[4];
    wire good_s = sync_reg[5];
    wire sleep_s = sync_reg[6];
    wire bov_s = sync_reg[7];
    wire vov_s = sync_reg[8];
    wire therm_s = sync_reg[9];
    wire sel_s = sync_reg[10];
    wire boostf_s = sync_reg[11];

    // ======================================================================
    // apb decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_stat = paddr == OFF_STATUS;
    wire hit_ctl = paddr == OFF_CONTROL;
    wire hit_par = paddr == OFF_CHGPARAM;
    wire hit_saf = paddr == OFF_SAFETY;
    wire hit_flg = paddr == OFF_FLAGS;
    wire mapped = hit_stat | hit_ctl | hit_par | hit_saf | hit_flg;

    logic [7:0] control_reg;
    logic [7:0] chgparam_reg;
    logic [7:0] safety_reg;
    logic stat_en_reg;
    logic [2:0] fault_code_reg;
    logic fault_held_reg;
    logic special_reg;
    logic mode32_reg;
    logic kick_seen_reg;
    chg_state_t state_reg;
    chg_state_t state_next;
    logic [39:0] tmr_reg;
    logic [39:0] wd_reg;
    logic [2:0] fault_code_next;
    logic fault_evt;
    logic pwrup_armed_reg;

    wire write_any = wr && mapped;
    wire kick = wr && hit_stat && pwdata[STAT_KICK_BIT];
    wire preset_wr = wr && hit_ctl && pwdata[CTL_PRESET_BIT];
    wire wd_expire = mode32_reg && !therm_s && (wd_reg == 40'h1);
    wire absent_evt = (state_reg == ST_BATCHK) && (tmr_reg == 40'h0) && !rch_s;
    // defaults except the safety register return on parameter reset, 32s expiry or missing battery
    wire restore = preset_wr || wd_expire || absent_evt;

    // ======================================================================
    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg <= CONTROL_RST;
            chgparam_reg <= CHGPARAM_RST;
            safety_reg <= SAFETY_RST;
            stat_en_reg <= STATUS_EN_RST[STAT_EN_BIT];
        end else if (restore) begin
            control_reg <= CONTROL_RST;
            chgparam_reg <= CHGPARAM_RST;
            stat_en_reg <= STATUS_EN_RST[STAT_EN_BIT];
        end else begin
            if (wr && hit_ctl) begin
                control_reg <= pwdata[7:0];
            end
            if (wr && hit_par) begin
                chgparam_reg <= pwdata[7:0];
            end
            if (wr && hit_saf) begin
                safety_reg <= pwdata[7:0];
            end
            if (wr && hit_stat) begin
                stat_en_reg <= pwdata[STAT_EN_BIT];
            end
        end
    end
    wire ncharge = control_reg[CTL_NCE_BIT];
    wire hz_bit = control_reg[CTL_HZ_BIT];

    // ======================================================================
    // timer mode: 15min until any write to a mapped register, then 32s watchdog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode32_reg <= 1'b0;
            kick_seen_reg <= 1'b0;
            wd_reg <= 40'h0;
        end else if (therm_s) begin
            mode32_reg <= mode32_reg;
        end else if (wd_expire) begin
            mode32_reg <= 1'b0;
            wd_reg <= 40'h0;
        end else if (write_any) begin
            mode32_reg <= 1'b1;
            kick_seen_reg <= kick_seen_reg | kick;
            if (!mode32_reg || kick) begin
                wd_reg <= 40'(T32_CYCLES);
            end
        end else if (mode32_reg && wd_reg != 40'h0) begin
            wd_reg <= wd_reg - 40'h1;
        end
    end

    // ======================================================================
    // charge state machine
    wire fault_now = therm_s || vov_s || bov_s || sleep_s;
    wire tmr_zero = tmr_reg == 40'h0;
    always_comb begin
        state_next = state_reg;
        fault_code_next = FLT_NONE;
        fault_evt = 1'b0;
        case (state_reg)
            ST_DETECT: begin
                if (!good_s) begin
                    state_next = ST_RETRY;
                    fault_code_next = FLT_BAD_ADAPT;
                    fault_evt = 1'b1;
                end else if (tmr_zero) begin
                    state_next = ST_CHARGE;
                end
            end
            ST_RETRY: begin
                if (tmr_zero) begin
                    state_next = ST_DETECT;
                end
            end
            ST_CHARGE: begin
                // the 262ms check borrows the counter, so its expiry is no timer fault
                if (!mode32_reg && !therm_s && tmr_zero && !kick_seen_reg && !pwrup_armed_reg) begin
                    state_next = ST_HIZ;
                    fault_code_next = FLT_TIMER;
                    fault_evt = 1'b1;
                end else if (mode32_reg && term_s && rch_s && control_reg[CTL_TERM_BIT]
                        && !fault_now) begin
                    state_next = ST_BATCHK;
                end
            end
            ST_BATCHK: begin
                if (tmr_zero) begin
                    if (rch_s) begin
                        state_next = ST_DONE;
                    end else begin
                        state_next = ST_RETRY;
                        fault_code_next = FLT_NO_BAT;
                        fault_evt = 1'b1;
                    end
                end
            end
            ST_DONE: begin
                if (!rch_s) begin
                    state_next = ST_CHARGE;
                end
            end
            ST_HIZ: begin
                if (mode32_reg) begin
                    state_next = ST_CHARGE;
                end
            end
            default: begin
                state_next = ST_DETECT;
            end
        endcase
    end

    // 15min run, 262ms power-up check and detect/retry waits share one counter
    logic short_prev_reg;
    wire leave_short = short_prev_reg && !short_s;
    wire pwrup_hiz = pwrup_armed_reg && tmr_zero && !mode32_reg && rch_s
        && state_reg == ST_CHARGE;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_DETECT;
            tmr_reg <= 40'(GOOD_CYCLES);
            pwrup_armed_reg <= 1'b0;
            short_prev_reg <= 1'b0;
        end else begin
            short_prev_reg <= short_s;
            if (pwrup_hiz) begin
                state_reg <= ST_HIZ;
                pwrup_armed_reg <= 1'b0;
            end else begin
                state_reg <= state_next;
            end
            if (state_next != state_reg) begin
                case (state_next)
                    ST_RETRY: tmr_reg <= 40'(RETRY_CYCLES);
                    ST_DETECT: tmr_reg <= 40'(GOOD_CYCLES);
                    ST_BATCHK: tmr_reg <= 40'(DETECT_CYCLES);
                    default: tmr_reg <= 40'(T15_CYCLES);
                endcase
            end else if (!mode32_reg && state_reg == ST_CHARGE && leave_short
                    && !pwrup_armed_reg) begin
                tmr_reg <= 40'(PWRUP_CYCLES);
                pwrup_armed_reg <= 1'b1;
            end else if (pwrup_armed_reg && tmr_zero) begin
                pwrup_armed_reg <= 1'b0;
                tmr_reg <= 40'(T15_CYCLES);
            end else if (wd_expire && state_reg == ST_CHARGE) begin
                tmr_reg <= 40'(T15_CYCLES);
            end else if (!therm_s && !tmr_zero) begin
                tmr_reg <= tmr_reg - 40'h1;
            end
        end
    end

    // ======================================================================
    // fault status, held until read
    logic vov_prev_reg;
    logic bov_prev_reg;
    logic th_prev_reg;
    logic sl_prev_reg;
    logic bf_prev_reg;
    wire vov_rise = vov_s && !vov_prev_reg;
    wire bov_rise = bov_s && !bov_prev_reg;
    wire th_rise = therm_s && !th_prev_reg;
    wire sl_rise = sleep_s && !sl_prev_reg && good_s;
    wire bf_rise = boostf_s && !bf_prev_reg;
    logic [2:0] async_code;
    always_comb begin
        async_code = fault_code_next;
        if (vov_rise) async_code = FLT_VBUS_OV;
        else if (bov_rise) async_code = FLT_BAT_OV;
        else if (th_rise) async_code = FLT_THERMAL;
        else if (sl_rise) async_code = FLT_SLEEP;
    end
    wire any_fault = fault_evt | vov_rise | bov_rise | th_rise | sl_rise;
    wire stat_read = rd && hit_stat;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_code_reg <= FLT_NONE;
            fault_held_reg <= 1'b0;
            special_reg <= 1'b0;
            {vov_prev_reg, bov_prev_reg, th_prev_reg, sl_prev_reg, bf_prev_reg} <= 5'h0;
        end else begin
            {vov_prev_reg, bov_prev_reg, th_prev_reg, sl_prev_reg, bf_prev_reg} <=
                {vov_s, bov_s, therm_s, sleep_s, boostf_s};
            // a fault arriving with the read wins over the release
            if (any_fault && (!fault_held_reg || stat_read)) begin
                fault_code_reg <= async_code;
                fault_held_reg <= 1'b1;
            end else if (stat_read) begin
                fault_held_reg <= 1'b0;
            end
            if (dpm_s && state_reg == ST_CHARGE) begin
                special_reg <= 1'b1;
            end else if (rd && hit_flg) begin
                special_reg <= 1'b0;
            end
        end
    end

    // ======================================================================
    // status pin pulse
    logic pulse_active;
    fault_pulse #(
        .LEN(PULSE_CYCLES)
    ) u_pulse (
        .pclk(pclk),
        .presetn(presetn),
        .trig(any_fault | bf_rise),
        .active(pulse_active)
    );

    // ======================================================================
    // outputs
    wire charging = (state_reg == ST_CHARGE || state_reg == ST_BATCHK) && !fault_now;
    // without host the default limit follows the select pin
    wire [1:0] lim15 = (HAS_SELECT_PIN && !sel_s) ? ILIM_100MA : ILIM_500MA;
    wire [1:0] lim32 = control_reg[CTL_IN_LIMIT_LSB +: 2];
    wire hiz15 = !mode32_reg && lowv_s;
    wire hiz_w = hiz15 || hz_bit || state_reg == ST_HIZ || ncharge;
    wire conv_w = (state_reg == ST_CHARGE) && !fault_now && !hiz_w;
    wire stat_low = pulse_active || (charging && stat_en_reg && !hiz_w);
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0;
        if (hit_stat) rdata = {24'h0, 1'b0, stat_en_reg, 1'b0, fault_held_reg,
            1'b0, fault_code_reg};
        else if (hit_ctl) rdata = {24'h0, control_reg};
        else if (hit_par) rdata = {24'h0, chgparam_reg};
        else if (hit_saf) rdata = {24'h0, safety_reg};
        else if (hit_flg) rdata = {27'h0, special_reg, 1'b0, mode32_reg, 2'h0};
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            stat_oe <= 1'b0;
            stat_out <= 1'b0;
            converter_en <= 1'b0;
            block_switch_en <= 1'b0;
            vbus_sink_en <= 1'b0;
            detect_sink_en <= 1'b0;
            short_current_mode <= 1'b0;
            dpm_reduce <= 1'b0;
            in_limit_sel <= ILIM_100MA;
            hi_z <= 1'b1;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= rdata;
            stat_oe <= stat_low;
            stat_out <= 1'b0;
            converter_en <= conv_w;
            block_switch_en <= !sleep_s && good_s;
            vbus_sink_en <= state_reg == ST_DETECT;
            detect_sink_en <= state_reg == ST_BATCHK;
            short_current_mode <= conv_w && short_s;
            dpm_reduce <= conv_w && dpm_s;
            in_limit_sel <= mode32_reg ? lim32 : lim15;
            hi_z <= hiz_w;
        end
    end

    // ======================================================================
    // checks
    a_detect_sink: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == ST_DETECT) |=> vbus_sink_en)
        else $error("sink not on during detect");
    a_bad_code: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == ST_DETECT && !good_s && !fault_held_reg
            && !(vov_rise | bov_rise | th_rise | sl_rise))
        |=> fault_code_reg == FLT_BAD_ADAPT)
        else $error("bad adaptor code missing");
    a_therm_off: assert property (@(posedge pclk) disable iff (!presetn)
        therm_s |=> !converter_en)
        else $error("converter on in thermal shutdown");
    a_vov_off: assert property (@(posedge pclk) disable iff (!presetn)
        vov_s |=> !converter_en)
        else $error("converter on in input overvoltage");
    a_bov_off: assert property (@(posedge pclk) disable iff (!presetn)
        bov_s |=> !converter_en)
        else $error("converter on in battery overvoltage");
    a_inhibit_off: assert property (@(posedge pclk) disable iff (!presetn)
        ncharge |=> !converter_en)
        else $error("charging while inhibited");
    a_pulse_low: assert property (@(posedge pclk) disable iff (!presetn)
        any_fault |=> ##1 stat_oe [*8])
        else $error("fault pulse not driven");
    a_preset_clear: assert property (@(posedge pclk) disable iff (!presetn)
        preset_wr |=> !control_reg[CTL_PRESET_BIT])
        else $error("parameter reset did not clear");
    a_limit_15: assert property (@(posedge pclk) disable iff (!presetn)
        !mode32_reg
        |=> in_limit_sel == ((HAS_SELECT_PIN && !$past(sel_s)) ? ILIM_100MA : ILIM_500MA))
        else $error("default limit wrong");
endmodule

//--- hdl/chg_sup_pkg.sv
/*
 * constants for the charge-mode supervisor: register offsets, fields, resets, timing.
 * assumes a 250 mhz pclk and 32-bit apb word access.
 */
package chg_sup_pkg;
    localparam int CLK_MHZ = 250;
    // register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CONTROL = 8'h04;
    localparam logic [7:0] OFF_CHGPARAM = 8'h14;
    localparam logic [7:0] OFF_SAFETY = 8'h18;
    localparam logic [7:0] OFF_FLAGS = 8'h1c;
    // control, status and flags register fields
    localparam int CTL_IN_LIMIT_LSB = 6;
    localparam int CTL_HZ_BIT = 1;
    localparam int CTL_NCE_BIT = 2;
    localparam int CTL_TERM_BIT = 3;
    localparam int CTL_PRESET_BIT = 7;
    localparam int STAT_KICK_BIT = 7;
    localparam int STAT_EN_BIT = 6;
    localparam int FLAG_SPECIAL_BIT = 4;
    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h30;
    localparam logic [7:0] CHGPARAM_RST = 8'h00;
    localparam logic [7:0] SAFETY_RST = 8'h00;
    localparam logic [7:0] STATUS_EN_RST = 8'h40;
    // fault codes in status bits 2..0
    localparam logic [2:0] FLT_NONE = 3'h0;
    localparam logic [2:0] FLT_VBUS_OV = 3'h1;
    localparam logic [2:0] FLT_SLEEP = 3'h2;
    localparam logic [2:0] FLT_BAD_ADAPT = 3'h3;
    localparam logic [2:0] FLT_BAT_OV = 3'h4;
    localparam logic [2:0] FLT_THERMAL = 3'h5;
    localparam logic [2:0] FLT_TIMER = 3'h6;
    localparam logic [2:0] FLT_NO_BAT = 3'h7;
    // input current limit codes
    localparam logic [1:0] ILIM_100MA = 2'h0;
    localparam logic [1:0] ILIM_500MA = 2'h1;
    // times
    localparam int PULSE_US = 128;
    localparam int GOOD_MS = 30;
    localparam int PWRUP_MS = 262;
    localparam int T32_S = 32;
    localparam int T15_MIN = 15;
    localparam int DETECT_MS = 30;
    localparam int RETRY_MS = 2;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam longint GOOD_CYC = longint'(GOOD_MS) * 1000 * CLK_MHZ;
    localparam longint PWRUP_CYC = longint'(PWRUP_MS) * 1000 * CLK_MHZ;
    localparam longint T32_CYC = longint'(T32_S) * 1000000 * CLK_MHZ;
    localparam longint T15_CYC = longint'(T15_MIN) * 60 * 1000000 * CLK_MHZ;
    localparam longint DETECT_CYC = longint'(DETECT_MS) * 1000 * CLK_MHZ;
    localparam longint RETRY_CYC = longint'(RETRY_MS) * 1000 * CLK_MHZ;
    typedef enum logic [2:0] {
        ST_DETECT = 3'h0,
        ST_RETRY = 3'h1,
        ST_CHARGE = 3'h2,
        ST_BATCHK = 3'h3,
        ST_DONE = 3'h4,
        ST_HIZ = 3'h5
    } chg_state_t;
endpackage

//--- hdl/fault_pulse.sv
/*
 * fault pulse generator for the open-drain status pin.
 * assumes a single pclk domain; trigger is a one-cycle pulse.
 */
`timescale 1ns/10ps
module fault_pulse #(
    parameter int LEN = 32000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trig,
    output logic active
);
    logic [31:0] cnt_reg;

    // a new fault restarts the pulse rather than stacking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 32'h0;
        end else if (trig) begin
            cnt_reg <= 32'(LEN);
        end else if (cnt_reg != 32'h0) begin
            cnt_reg <= cnt_reg - 32'h1;
        end
    end

    assign active = (cnt_reg != 32'h0);
endmodule

//--- test/status_host_model.sv
/*
 * host-side view of the open-drain status pin: measures low pulses.
 * assumes a pull-up on the pin and the pclk of the supervisor.
 */
`timescale 1ns/10ps
// ==========================================
// status pin observer
module status_host_model (
    input wire logic pclk,
    input wire logic stat_oe,
    input wire logic stat_out,
    output logic [31:0] last_low
);
    // pull-up wins whenever the pin is released
    wire stat_pin = stat_oe ? stat_out : 1'b1;
    logic [31:0] run = 32'h0;
    always @(posedge pclk) begin
        if (stat_pin === 1'b0) begin
            run <= run + 32'h1;
        end else begin
            if (run != 32'h0) last_low <= run;
            run <= 32'h0;
        end
    end
endmodule

//--- test/charger_mode_supervisor_tb_top.sv
/*
 * apb-driven testbench for the charge-mode supervisor.
 * assumes shortened timer parameters and the status pin observer.
 */
`timescale 1ns/10ps
// ==========================================
// bench
module charger_mode_supervisor_tb_top;
    import chg_sup_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sel = 0, good = 0;
    logic dpm = 0, shrt = 0, lowv = 0, rch = 0, term = 0, bst = 0;
    logic [3:0] flt = 4'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, r, low;
    logic pready, pslverr, e, stat_oe, stat_out, conv, blk, ssm, dred, sink, dsink, hiz;
    logic [1:0] ilim;
    int n_mismatch = 0, tests_run = 0;
    always #2 pclk = ~pclk;
    charger_mode_supervisor #(.GOOD_CYCLES(50), .PWRUP_CYCLES(80), .T32_CYCLES(200),
        .T15_CYCLES(400), .DETECT_CYCLES(20), .RETRY_CYCLES(30), .PULSE_CYCLES(16)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_select_pin(sel), .thermal_shutdown_in(flt[0]), .vbus_ov_in(flt[1]),
        .bat_ov_in(flt[2]), .vbus_sleep_in(flt[3]), .vbus_good_in(good), .vbus_dpm_in(dpm),
        .bat_above_lowv_in(lowv), .bat_above_rch_in(rch), .bat_short_in(shrt),
        .term_current_in(term), .boost_fault_in(bst), .stat_oe(stat_oe),
        .stat_out(stat_out), .converter_en(conv), .block_switch_en(blk), .vbus_sink_en(sink),
        .detect_sink_en(dsink), .short_current_mode(ssm), .dpm_reduce(dred),
        .in_limit_sel(ilim), .hi_z(hiz));
    status_host_model host_u (.pclk(pclk), .stat_oe(stat_oe), .stat_out(stat_out),
        .last_low(low));
    // ==========================================
    // tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: a following call never reassigns psel in the same step
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================
    // tests
    initial begin
        cyc(3000); // far beyond the ~1600 cycles of the sequence
        n_mismatch++;
        summarize();
    end
    initial begin
        cyc(10);
        presetn <= 1'b1;
        xfer(0, OFF_CONTROL, 0);
        chk(r, {24'h0, CONTROL_RST});
        xfer(0, 8'h08, 0); // unmapped
        chk({e, r[30:0]}, 32'h80000000);
        cyc(20);
        chk(low, 32'd16);
        xfer(0, OFF_STATUS, 0);
        chk({sink, r[2:0]}, {1'b0, FLT_BAD_ADAPT});
        $display("test adaptor done");
        good <= 1'b1;
        cyc(30);
        chk(sink, 1'b1);
        cyc(90);
        chk({stat_oe, conv, ilim}, {2'b11, ILIM_100MA});
        sel <= 1'b1;
        shrt <= 1'b1;
        dpm <= 1'b1;
        cyc(5);
        chk({ssm, dred, ilim}, {2'b11, ILIM_500MA});
        xfer(0, OFF_FLAGS, 0);
        chk(r[FLAG_SPECIAL_BIT], 1'b1);
        {sel, shrt, dpm} <= 3'b000;
        for (int i = 0; i < 4; i++) begin
            flt <= 4'h1 << i;
            cyc(5);
            chk({conv, blk}, {1'b0, i != 3});
            flt <= 4'h0;
            cyc(i == 3 ? 70 : 10);
            chk(conv, 1'b1);
        end
        xfer(0, OFF_STATUS, 0);
        chk(r[2:0], FLT_THERMAL);
        $display("test faults done");
        xfer(1, OFF_CONTROL, 32'h74);
        cyc(3);
        chk({conv, ilim}, {1'b0, 2'h1});
        xfer(1, OFF_CONTROL, 32'h70);
        cyc(3);
        chk(conv, 1'b1);
        cyc(250);
        chk(ilim, ILIM_100MA);
        xfer(1, OFF_CONTROL, 32'h70);
        xfer(1, OFF_CONTROL, 32'h80);
        xfer(0, OFF_CONTROL, 0);
        chk(r, {24'h0, CONTROL_RST});
        cyc(700);
        xfer(0, OFF_STATUS, 0);
        chk({conv, r[2:0]}, {1'b0, FLT_TIMER});
        $display("test timers done");
        bst <= 1'b1;
        cyc(5);
        chk(stat_oe, 1'b1);
        bst <= 1'b0;
        cyc(20);
        chk({stat_oe, sink, hiz}, 3'b001);
        xfer(1, OFF_CONTROL, 32'h38);
        term <= 1'b1;
        rch <= 1'b1;
        cyc(6);
        chk(dsink, 1'b1);
        cyc(30);
        chk({dsink, conv}, 2'b00);
        rch <= 1'b0;
        cyc(5);
        chk(conv, 1'b1);
        rch <= 1'b1;
        cyc(6);
        rch <= 1'b0;
        cyc(25);
        xfer(0, OFF_CONTROL, 0);
        chk(r, {24'h0, CONTROL_RST});
        xfer(0, OFF_STATUS, 0);
        chk({conv, r[2:0]}, {1'b0, FLT_NO_BAT});
        $display("test battery done");
        cyc(135);
        chk({hiz, conv}, 2'b01);
        lowv <= 1'b1;
        cyc(5);
        chk({hiz, conv}, 2'b10);
        {lowv, rch, shrt} <= 3'b011;
        cyc(5);
        chk({hiz, conv}, 2'b01);
        shrt <= 1'b0;
        cyc(90);
        chk({hiz, conv}, 2'b10);
        $display("test power-up done");
        summarize();
    end
endmodule
